// file: hdl/usb_dma_pkg.sv
// Shared constants, types and register map of the endpoint DMA block
package usb_dma_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] CTRL_OFF    = 8'h00;
  localparam logic [7:0] ERR_OFF     = 8'h04;
  localparam logic [7:0] CHEN_OFF    = 8'h08;
  localparam logic [7:0] SWREQ_OFF   = 8'h0c;
  localparam logic [7:0] MODE_OFF    = 8'h10;
  localparam logic [7:0] XFER_OFF    = 8'h14;
  localparam logic [7:0] BURST_OFF   = 8'h18;
  localparam logic [7:0] EPCFG_OFF   = 8'h1c;
  localparam logic [7:0] IRQST_OFF   = 8'h20;
  localparam logic [7:0] IRQMSK_OFF  = 8'h24;

  // Channel layout: endpoint e owns channels 2e-2 (rx) and 2e-1 (tx)
  localparam int NUM_EP       = 3;
  localparam int NUM_CH       = 7;
  localparam int SW_CH        = 6;
  localparam int CNT_W        = 10;
  localparam int NUM_IRQ      = 5;

  // Field positions
  localparam int CTRL_EN_BIT  = 0;
  localparam int SWREQ_BIT    = 0;
  localparam int XFER_SEL_LSB = 16;
  localparam int IRQ_SW_BIT   = 0;
  localparam int IRQ_ERR_BIT  = 1;
  localparam int IRQ_EP_LSB   = 2;
  // Endpoint config, 4 bits per endpoint
  localparam int EPCFG_W      = 4;
  localparam int EPCFG_MODE   = 0;
  localparam int EPCFG_AUTO   = 1;
  localparam int EPCFG_IN     = 2;

  // Reset values
  localparam logic [31:0] REG_RST = 32'h0000_0000;

  // Channel transfer modes
  typedef enum logic [1:0] {
    stopped_mode           = 2'b00,
    basic_mode             = 2'b01,
    run_to_completion_mode = 2'b10
  } ch_mode_t;

  // Engine states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } eng_state_t;

  // Per-endpoint signals from the USB protocol engine
  typedef struct packed {
    logic burst_req;
    logic single_req;
    logic space_avail;
    logic ep_error;
    logic pkt_full;
  } ep_evt_t;
endpackage

// file: hdl/usb_endpoint_dma_channels.sv
// Endpoint DMA channels with software channel, error and interrupt logic
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Sticky error status reads non-zero while a bus error is pending.
// - Writing one to the error status clears the pending error interrupt.
// - Software channel completion raises its own completion interrupt line.
// - Endpoint channel completion goes to that endpoint's interrupt only.
// - Run-to-completion channel finishes its whole count once requested.
// - Endpoint 0 is never served by any DMA channel.
// - Endpoints 1 to 3 each get one receive and one transmit channel.
// - Host IN and device OUT use receive; others use transmit.
// - Per-packet mode interrupts each time transmit FIFO space frees up.
// - Completion-only mode interrupts only on completion or error.
// - Auto packet send marks a full FIFO packet ready without software.
// - A finished channel has its enable cleared by the controller.
// - A finished channel has its mode field set to stopped.
module usb_endpoint_dma_channels (
  input  wire logic                                 core_clk_i,
  input  wire logic                                 rst_i,
  input  wire logic                                 wb_cyc_i,
  input  wire logic                                 wb_stb_i,
  input  wire logic                                 wb_we_i,
  input  wire logic [7:0]                           wb_adr_i,
  input  wire logic [3:0]                           wb_sel_i,
  input  wire logic [31:0]                          wb_dat_i,
  output logic      [31:0]                          wb_dat_o,
  output logic                                      wb_ack_o,
  input  wire logic                                 usb_host_mode_i,
  input  wire usb_dma_pkg::ep_evt_t [usb_dma_pkg::NUM_EP-1:0] ep_evt_i,
  output logic      [usb_dma_pkg::NUM_EP-1:0]       packet_ready_o,
  output logic                                      mem_req_o,
  output logic      [2:0]                           mem_ch_o,
  input  wire logic                                 mem_ack_i,
  input  wire logic                                 mem_err_i,
  output logic                                      sw_channel_completion_irq_o,
  output logic                                      bus_error_irq_o,
  output logic      [usb_dma_pkg::NUM_EP-1:0]       ep_irq_o,
  output logic                                      irq_o
);
  localparam int NCH = usb_dma_pkg::NUM_CH;
  localparam int NEP = usb_dma_pkg::NUM_EP;

  logic                     ctrl_en;
  logic [NCH-1:0]           ch_en;
  logic [NCH-1:0]           burst_only;
  logic [2*NCH-1:0]         mode;
  logic [2*NCH-1:0]         next_mode;
  logic [NEP*4-1:0]         ep_cfg;
  logic [2:0]               xfer_sel;
  logic [usb_dma_pkg::CNT_W-1:0] cnt [NCH];
  logic                     sw_req_pend;
  logic [usb_dma_pkg::NUM_IRQ-1:0] irq_status;
  logic [usb_dma_pkg::NUM_IRQ-1:0] irq_mask;
  logic [usb_dma_pkg::NUM_IRQ-1:0] irq_set;
  usb_dma_pkg::eng_state_t  state;
  logic [2:0]               cur;
  logic [NCH-1:0]           ch_req;
  logic [NCH-1:0]           done_vec;
  logic [NCH-1:0]           stop_vec;
  logic                     fin;
  logic                     err_hit;
  logic                     grant;
  logic [2:0]               grant_ch;
  logic                     bus_req;
  logic                     wr;
  logic [31:0]              wmask;
  logic [31:0]              rdata;

  // Wishbone request decode; write lands on the edge that raises ack
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr      = bus_req & wb_we_i;
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // One wait-free cycle: ack follows the request edge, then drops
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= usb_dma_pkg::REG_RST;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req) begin
        wb_dat_o <= rdata;
      end
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rdata = 32'h0000_0000;
    case (wb_adr_i)
      usb_dma_pkg::CTRL_OFF:   rdata[usb_dma_pkg::CTRL_EN_BIT] = ctrl_en;
      usb_dma_pkg::ERR_OFF:    rdata[0] = irq_status[usb_dma_pkg::IRQ_ERR_BIT];
      usb_dma_pkg::CHEN_OFF:   rdata[NCH-1:0] = ch_en;
      usb_dma_pkg::SWREQ_OFF:  rdata[usb_dma_pkg::SWREQ_BIT] = sw_req_pend;
      usb_dma_pkg::MODE_OFF:   rdata[2*NCH-1:0] = mode;
      usb_dma_pkg::XFER_OFF:   rdata = {13'h0000, xfer_sel, 6'h00, cnt[xfer_sel]};
      usb_dma_pkg::BURST_OFF:  rdata[NCH-1:0] = burst_only;
      usb_dma_pkg::EPCFG_OFF:  rdata[NEP*4-1:0] = ep_cfg;
      usb_dma_pkg::IRQST_OFF:  rdata[usb_dma_pkg::NUM_IRQ-1:0] = irq_status;
      usb_dma_pkg::IRQMSK_OFF: rdata[usb_dma_pkg::NUM_IRQ-1:0] = irq_mask;
      default:                 rdata = 32'h0000_0000;
    endcase
  end

  // Plain configuration registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_en    <= 1'b0;
      burst_only <= '0;
      ep_cfg     <= '0;
      irq_mask   <= '0;
    end else if (wr) begin
      case (wb_adr_i)
        usb_dma_pkg::CTRL_OFF:
          ctrl_en <= 1'(merge({31'h0, ctrl_en}, wb_dat_i, wmask)); // Enable sits in bit 0
        usb_dma_pkg::BURST_OFF:
          burst_only <= NCH'(merge({25'h0, burst_only}, wb_dat_i, wmask));
        usb_dma_pkg::EPCFG_OFF:
          ep_cfg <= (NEP*4)'(merge({20'h0, ep_cfg}, wb_dat_i, wmask));
        usb_dma_pkg::IRQMSK_OFF:
          irq_mask <= (usb_dma_pkg::NUM_IRQ)'(merge({27'h0, irq_mask}, wb_dat_i, wmask));
        default: ;
      endcase
    end
  end

  // Channel enables; hardware stop beats a same-cycle software write
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ch_en <= '0;
    end else if (wr && wb_adr_i == usb_dma_pkg::CHEN_OFF) begin
      ch_en <= NCH'(merge({25'h0, ch_en}, wb_dat_i, wmask)) & ~stop_vec;
    end else begin
      ch_en <= ch_en & ~stop_vec;
    end
  end

  // Mode fields; the engine writes stopped back at the end of a transfer
  always_comb begin
    next_mode = mode;
    if (wr && wb_adr_i == usb_dma_pkg::MODE_OFF) begin
      next_mode = (2*NCH)'(merge({18'h0, mode}, wb_dat_i, wmask));
    end
    for (int c = 0; c < NCH; c++) begin
      if (done_vec[c]) begin
        next_mode[2*c +: 2] = usb_dma_pkg::stopped_mode;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode <= '0;
    end else begin
      mode <= next_mode;
    end
  end

  // Item counts, loaded through a channel-select window
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      xfer_sel <= 3'h0;
      for (int c = 0; c < NCH; c++) begin
        cnt[c] <= '0;
      end
    end else begin
      if (wr && wb_adr_i == usb_dma_pkg::XFER_OFF) begin
        xfer_sel      <= wb_dat_i[usb_dma_pkg::XFER_SEL_LSB +: 3];
        cnt[wb_dat_i[usb_dma_pkg::XFER_SEL_LSB +: 3]] <= wb_dat_i[usb_dma_pkg::CNT_W-1:0];
      end
      if (state == usb_dma_pkg::ST_BUSY && mem_ack_i) begin
        cnt[cur] <= cnt[cur] - 1'b1; // Engine wins over a stray reload
      end
    end
  end

  // Software request latch; a new request wins over the grant clear
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sw_req_pend <= 1'b0;
    end else if (wr && wb_adr_i == usb_dma_pkg::SWREQ_OFF && wb_sel_i[0]
                 && wb_dat_i[usb_dma_pkg::SWREQ_BIT]) begin
      sw_req_pend <= 1'b1;
    end else if (grant && grant_ch == 3'(usb_dma_pkg::SW_CH)) begin
      sw_req_pend <= 1'b0;
    end
  end

  // Endpoint 0 has no channel; endpoints 1..3 get an rx/tx pair each
  genvar e;
  generate
    for (e = 0; e < NEP; e++) begin : g_ep
      logic rx_route;
      logic ep_req;
      logic [3:0] cfg;
      assign cfg      = ep_cfg[4*e +: 4];
      // Host IN and device OUT move data into memory
      assign rx_route = (usb_host_mode_i == cfg[usb_dma_pkg::EPCFG_IN]);
      assign ep_req   = ep_evt_i[e].burst_req;
      // Burst-only channels ignore single requests
      assign ch_req[2*e]   = rx_route & (ep_req | (ep_evt_i[e].single_req & ~burst_only[2*e]));
      assign ch_req[2*e+1] = ~rx_route & (ep_req | (ep_evt_i[e].single_req
                                                     & ~burst_only[2*e+1]));
      // Per-packet mode also flags freed transmit space; done always flags
      assign irq_set[usb_dma_pkg::IRQ_EP_LSB+e] =
          done_vec[2*e] | done_vec[2*e+1] | ep_evt_i[e].ep_error |
          (~cfg[usb_dma_pkg::EPCFG_MODE] & ~rx_route & ep_evt_i[e].space_avail);
      // Auto send: full packet in a transmit FIFO goes out by itself
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          packet_ready_o[e] <= 1'b0;
        end else begin
          packet_ready_o[e] <= cfg[usb_dma_pkg::EPCFG_AUTO] & ~rx_route
                               & ep_evt_i[e].pkt_full;
        end
      end
      assign ep_irq_o[e] = irq_status[usb_dma_pkg::IRQ_EP_LSB+e]
                           & irq_mask[usb_dma_pkg::IRQ_EP_LSB+e];
    end
  endgenerate
  assign ch_req[usb_dma_pkg::SW_CH] = sw_req_pend;

  // Fixed priority, lowest channel first; nothing while disabled
  always_comb begin
    grant    = 1'b0;
    grant_ch = 3'h0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (ch_req[c] && ch_en[c] && cnt[c] != '0
          && mode[2*c +: 2] != usb_dma_pkg::stopped_mode) begin
        grant    = ctrl_en && state == usb_dma_pkg::ST_IDLE;
        grant_ch = 3'(c);
      end
    end
  end

  // Last item acked, or bus error on the active channel
  assign fin      = state == usb_dma_pkg::ST_BUSY && mem_ack_i && !mem_err_i
                    && cnt[cur] == 10'h001;
  assign err_hit  = state == usb_dma_pkg::ST_BUSY && mem_err_i;
  assign done_vec = fin ? NCH'(1) << cur : '0;
  assign stop_vec = done_vec | (err_hit ? NCH'(1) << cur : '0);

  // Transfer engine: one item per memory handshake
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= usb_dma_pkg::ST_IDLE;
      cur   <= 3'h0;
    end else begin
      case (state)
        usb_dma_pkg::ST_IDLE: begin
          if (grant) begin
            state <= usb_dma_pkg::ST_BUSY;
            cur   <= grant_ch;
          end
        end
        usb_dma_pkg::ST_BUSY: begin
          if (err_hit || fin) begin
            state <= usb_dma_pkg::ST_IDLE;
          end else if (mem_ack_i && mode[2*cur +: 2] == usb_dma_pkg::basic_mode
                       && !ch_req[cur]) begin
            state <= usb_dma_pkg::ST_IDLE; // Basic mode yields when request drops
          end
          // Run-to-completion ignores the request line once started
        end
        default: state <= usb_dma_pkg::ST_IDLE;
      endcase
    end
  end
  assign mem_req_o = state == usb_dma_pkg::ST_BUSY;
  assign mem_ch_o  = cur;

  // Sticky interrupt status: a new event beats a same-cycle clear
  assign irq_set[usb_dma_pkg::IRQ_SW_BIT]  = done_vec[usb_dma_pkg::SW_CH];
  assign irq_set[usb_dma_pkg::IRQ_ERR_BIT] = err_hit;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status <= '0;
    end else if (wr && wb_adr_i == usb_dma_pkg::IRQST_OFF && wb_sel_i[0]) begin
      irq_status <= (irq_status & ~wb_dat_i[usb_dma_pkg::NUM_IRQ-1:0]) | irq_set;
    end else if (wr && wb_adr_i == usb_dma_pkg::ERR_OFF && wb_sel_i[0]) begin
      irq_status <= (irq_status & ~{3'h0, wb_dat_i[0], 1'b0}) | irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end
  assign sw_channel_completion_irq_o = irq_status[usb_dma_pkg::IRQ_SW_BIT]
                                       & irq_mask[usb_dma_pkg::IRQ_SW_BIT];
  assign bus_error_irq_o = irq_status[usb_dma_pkg::IRQ_ERR_BIT]
                           & irq_mask[usb_dma_pkg::IRQ_ERR_BIT];
  assign irq_o = |(irq_status & irq_mask);

  // Checks next to the logic they guard
  chk_err_sticky: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (bus_req && !wb_we_i && wb_adr_i == usb_dma_pkg::ERR_OFF)
    |=> (wb_dat_o != 32'h0000_0000) == $past(irq_status[usb_dma_pkg::IRQ_ERR_BIT]))
    else $error("error status read-back disagrees with pending error");
  chk_err_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (wr && wb_adr_i == usb_dma_pkg::ERR_OFF && wb_sel_i[0] && wb_dat_i[0] && !err_hit)
    |=> !irq_status[usb_dma_pkg::IRQ_ERR_BIT] && !bus_error_irq_o)
    else $error("error clear did not remove pending error");
  chk_sw_done_irq: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (fin && cur == 3'(usb_dma_pkg::SW_CH)) |=> irq_status[usb_dma_pkg::IRQ_SW_BIT])
    else $error("software channel completion not flagged");
  chk_sw_irq_cause: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(irq_status[usb_dma_pkg::IRQ_SW_BIT]) |-> $past(done_vec[usb_dma_pkg::SW_CH]))
    else $error("completion irq raised by an endpoint channel");
  chk_rtc_holds: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state == usb_dma_pkg::ST_BUSY && !fin && !err_hit
     && mode[2*cur +: 2] == usb_dma_pkg::run_to_completion_mode)
    |=> state == usb_dma_pkg::ST_BUSY && $stable(cur))
    else $error("run-to-completion channel released early");
  chk_done_disable: assert property (@(posedge core_clk_i) disable iff (rst_i)
    fin |=> !ch_en[$past(cur)] && state == usb_dma_pkg::ST_IDLE)
    else $error("finished channel still enabled");
  chk_done_stopped: assert property (@(posedge core_clk_i) disable iff (rst_i)
    fin |=> mode[2*$past(cur) +: 2] == usb_dma_pkg::stopped_mode)
    else $error("finished channel mode not stopped");
  chk_err_stops: assert property (@(posedge core_clk_i) disable iff (rst_i)
    err_hit |=> !ch_en[$past(cur)] && !mem_req_o ##0 irq_status[usb_dma_pkg::IRQ_ERR_BIT])
    else $error("bus error did not stop the channel");
  chk_grant_enabled: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(mem_req_o) |-> $past(ctrl_en && ch_en[grant_ch]))
    else $error("transfer started while disabled");
  chk_auto_send: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(packet_ready_o[0]) |-> $past(ep_cfg[usb_dma_pkg::EPCFG_AUTO]
                                      && ep_evt_i[0].pkt_full))
    else $error("packet marked ready without auto send");

endmodule
`default_nettype wire

// file: tb/mem_responder.sv
// Memory-side responder that answers engine item requests
`timescale 1ns/100ps
`default_nettype none

module mem_responder (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       mem_req_i,
  input  wire logic [3:0] delay_i,
  input  wire logic       err_i,
  output logic            mem_ack_o,
  output logic            mem_err_o
);
  logic [3:0] wait_cnt;
  logic       hit;

  // Wait cycles before each answer, restarted per item
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_cnt <= 4'h0;
    end else if (!mem_req_i || hit) begin
      wait_cnt <= 4'h0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  // Answer only while asked, so an idle engine never sees a stray ack
  // Items carry no address; err_i decides between ack and error at each answer
  assign hit       = mem_req_i && (wait_cnt == delay_i);
  assign mem_ack_o = hit && !err_i;
  assign mem_err_o = hit && err_i;
endmodule

`default_nettype wire

// file: tb/usb_endpoint_dma_channels_test.sv
// Self-checking bench for the endpoint DMA channels
`timescale 1ns/100ps
`default_nettype none

module usb_endpoint_dma_channels_test;
  typedef struct packed {
    logic [1:0] src;
    logic       host;
    logic       is_in;
    logic [9:0] cnt;
    logic [3:0] dly;
    logic [2:0] ch;
    logic [4:0] irq;
  } row_t;
  // Source 3 is the software channel, 0..2 are endpoints 1..3
  row_t rows [6] = '{
    '{2'h3, 1'b0, 1'b0, 10'h002, 4'h0, 3'h6, 5'h01},
    '{2'h0, 1'b0, 1'b1, 10'h003, 4'h0, 3'h1, 5'h04},
    '{2'h1, 1'b1, 1'b1, 10'h002, 4'h1, 3'h2, 5'h08},
    '{2'h2, 1'b0, 1'b0, 10'h004, 4'h0, 3'h4, 5'h10},
    '{2'h0, 1'b1, 1'b0, 10'h003, 4'h2, 3'h1, 5'h04},
    '{2'h3, 1'b0, 1'b0, 10'h001, 4'h3, 3'h6, 5'h01}};
  logic                          core_clk_i = 1'b0;
  logic                          rst_i      = 1'b1;
  logic                          wb_cyc     = 1'b0;
  logic                          wb_stb     = 1'b0;
  logic                          wb_we      = 1'b0;
  logic [7:0]                    wb_adr     = 8'h00;
  logic [3:0]                    wb_sel     = 4'h0;
  logic [31:0]                   wb_wdat    = 32'h0;
  logic [31:0]                   wb_rdat;
  logic                          wb_ack;
  logic                          host_mode  = 1'b0;
  usb_dma_pkg::ep_evt_t [2:0]    ep_evt     = '0;
  logic [2:0]                    pkt_rdy, ep_irq, mem_ch, seen_ch;
  logic                          mem_req, mem_ack, mem_err, sw_irq, err_irq, irq;
  logic [3:0]                    delay      = 4'h0;
  logic                          err_arm    = 1'b0;
  logic [31:0]                   v;
  int                            n_fail = 0, n_tests = 0, n_items = 0, cycles = 0, base, t;
  row_t                          r;

  always #50 core_clk_i = ~core_clk_i;

  usb_endpoint_dma_channels dut_u (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .usb_host_mode_i(host_mode), .ep_evt_i(ep_evt),
    .packet_ready_o(pkt_rdy), .mem_req_o(mem_req), .mem_ch_o(mem_ch), .mem_ack_i(mem_ack),
    .mem_err_i(mem_err), .sw_channel_completion_irq_o(sw_irq), .bus_error_irq_o(err_irq),
    .ep_irq_o(ep_irq), .irq_o(irq));

  mem_responder resp_u (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .mem_req_i(mem_req), .delay_i(delay),
    .err_i(err_arm), .mem_ack_o(mem_ack), .mem_err_o(mem_err));

  // Count answered items and remember which channel was served
  always @(posedge core_clk_i) begin
    cycles++;
    if (mem_ack === 1'b1) begin
      n_items++;
      seen_ch <= mem_ch;
    end
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Classic cycle: hold everything until ack is seen, release at that edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int k = 0;
    @(posedge core_clk_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_wdat <= dat;
    wb_sel  <= 4'hf;
    do @(posedge core_clk_i); while (wb_ack !== 1'b1 && k++ < 50);
    if (wb_ack !== 1'b1) begin
      n_fail++;
      end_of_test();
    end
    v = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  // One-cycle event on an endpoint: {burst, single, space, error, full}
  task automatic ev(input logic [1:0] e, input logic [4:0] bits);
    @(posedge core_clk_i);
    ep_evt[e] <= bits;
    @(posedge core_clk_i);
    ep_evt[e] <= 5'h00;
  endtask

  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(negedge core_clk_i);
    chk("idle outputs", 32'h0, {irq, sw_irq, err_irq, ep_irq, mem_req, pkt_rdy});
    wb(1'b0, usb_dma_pkg::CTRL_OFF, 32'h0);
    chk("ctrl reset", 32'h0, v);
    wb(1'b0, usb_dma_pkg::XFER_OFF, 32'h0);
    chk("xfer reset", 32'h0, v);
    $display("reset test done");
    // Controller first, then attributes cleared and burst-only set
    wb(1'b1, usb_dma_pkg::CTRL_OFF, 32'h1);
    wb(1'b1, usb_dma_pkg::BURST_OFF, 32'h0);
    wb(1'b1, usb_dma_pkg::BURST_OFF, 32'h3f);
    wb(1'b1, usb_dma_pkg::IRQMSK_OFF, 32'h1f);
    foreach (rows[i]) begin
      r = rows[i];
      host_mode <= r.host;
      delay <= r.dly;
      wb(1'b1, usb_dma_pkg::EPCFG_OFF, {20'h0, {3{1'b0, r.is_in, 2'b01}}});
      wb(1'b1, usb_dma_pkg::MODE_OFF, 32'h2 << (2 * r.ch));
      wb(1'b1, usb_dma_pkg::XFER_OFF, {13'h0, r.ch, 6'h0, r.cnt});
      base = n_items;
      wb(1'b1, usb_dma_pkg::CHEN_OFF, 32'h1 << r.ch);
      // A single burst pulse must still carry the whole count
      if (r.src == 2'h3) wb(1'b1, usb_dma_pkg::SWREQ_OFF, 32'h1);
      else ev(r.src, 5'h10);
      t = 0;
      do @(negedge core_clk_i); while (!(n_items - base == r.cnt && mem_req === 1'b0) && t++ < 300);
      chk("items", r.cnt, n_items - base);
      chk("channel", r.ch, seen_ch);
      wb(1'b0, usb_dma_pkg::CHEN_OFF, 32'h0);
      chk("enable", 32'h0, v);
      wb(1'b0, usb_dma_pkg::MODE_OFF, 32'h0);
      chk("mode", 32'h0, v);
      wb(1'b0, usb_dma_pkg::IRQST_OFF, 32'h0);
      chk("irq status", r.irq, v);
      chk("irq lines", {r.irq[0], r.irq[4:2]}, {sw_irq, ep_irq});
      wb(1'b1, usb_dma_pkg::IRQST_OFF, 32'h1f);
      $display("row %0d done", i);
    end
    // Disabled controller must ignore a complete software setup
    wb(1'b1, usb_dma_pkg::CTRL_OFF, 32'h0);
    wb(1'b1, usb_dma_pkg::MODE_OFF, 32'h2000);
    wb(1'b1, usb_dma_pkg::XFER_OFF, 32'h0006_0001);
    base = n_items;
    wb(1'b1, usb_dma_pkg::CHEN_OFF, 32'h40);
    wb(1'b1, usb_dma_pkg::SWREQ_OFF, 32'h1);
    repeat (10) @(negedge core_clk_i);
    chk("disabled items", 32'h0, n_items - base);
    wb(1'b1, usb_dma_pkg::CHEN_OFF, 32'h0);
    $display("disabled test done");
    // Bus error on the first item of a run
    err_arm <= 1'b1;
    wb(1'b1, usb_dma_pkg::CTRL_OFF, 32'h1);
    wb(1'b1, usb_dma_pkg::XFER_OFF, 32'h0006_0003);
    wb(1'b1, usb_dma_pkg::CHEN_OFF, 32'h40);
    wb(1'b1, usb_dma_pkg::SWREQ_OFF, 32'h1);
    t = 0;
    do @(negedge core_clk_i); while (err_irq !== 1'b1 && t++ < 50);
    chk("error irq", 32'h3, {irq, err_irq});
    @(posedge core_clk_i);
    err_arm <= 1'b0;
    wb(1'b0, usb_dma_pkg::ERR_OFF, 32'h0);
    chk("error pending", 32'h1, v != 32'h0);
    wb(1'b0, usb_dma_pkg::CHEN_OFF, 32'h0);
    chk("error enable", 32'h0, v);
    wb(1'b1, usb_dma_pkg::ERR_OFF, 32'h1);
    wb(1'b0, usb_dma_pkg::ERR_OFF, 32'h0);
    chk("error cleared", 32'h0, v);
    @(negedge core_clk_i);
    chk("error irq off", 32'h0, err_irq);
    $display("error test done");
    // Space events by endpoint mode, device IN on endpoint 1
    @(posedge core_clk_i);
    host_mode <= 1'b0;
    wb(1'b1, usb_dma_pkg::EPCFG_OFF, 32'h4);
    ev(2'h0, 5'h04);
    wb(1'b0, usb_dma_pkg::IRQST_OFF, 32'h0);
    chk("space mode0", 32'h4, v);
    wb(1'b1, usb_dma_pkg::IRQMSK_OFF, 32'h0);
    @(negedge core_clk_i);
    chk("masked irq", 32'h0, {irq, ep_irq});
    wb(1'b1, usb_dma_pkg::IRQST_OFF, 32'h1f);
    wb(1'b1, usb_dma_pkg::EPCFG_OFF, 32'h5);
    ev(2'h0, 5'h04);
    wb(1'b0, usb_dma_pkg::IRQST_OFF, 32'h0);
    chk("space mode1", 32'h0, v);
    ev(2'h0, 5'h02);
    wb(1'b1, usb_dma_pkg::IRQMSK_OFF, 32'h1f);
    wb(1'b0, usb_dma_pkg::IRQST_OFF, 32'h0);
    chk("error mode1", 32'h4, v);
    @(negedge core_clk_i);
    chk("ep irq", 32'h3, {irq, ep_irq[0]});
    wb(1'b1, usb_dma_pkg::IRQST_OFF, 32'h1f);
    $display("endpoint mode test done");
    // Full packet with and without automatic send
    wb(1'b1, usb_dma_pkg::EPCFG_OFF, 32'h6);
    @(posedge core_clk_i);
    ep_evt[0] <= 5'h01;
    repeat (3) @(negedge core_clk_i);
    chk("auto send", 32'h1, pkt_rdy);
    wb(1'b1, usb_dma_pkg::EPCFG_OFF, 32'h4);
    repeat (3) @(negedge core_clk_i);
    chk("no auto send", 32'h0, pkt_rdy);
    @(posedge core_clk_i);
    ep_evt[0] <= 5'h00;
    $display("auto send test done");
    // Basic mode yields the bus once its one-cycle request is gone
    wb(1'b1, usb_dma_pkg::MODE_OFF, 32'h4);
    wb(1'b1, usb_dma_pkg::XFER_OFF, 32'h0001_0003);
    base = n_items;
    wb(1'b1, usb_dma_pkg::CHEN_OFF, 32'h2);
    ev(2'h0, 5'h10);
    repeat (12) @(negedge core_clk_i);
    chk("basic items", 32'h1, n_items - base);
    wb(1'b0, usb_dma_pkg::CHEN_OFF, 32'h0);
    chk("basic enable", 32'h2, v);
    $display("basic mode test done");
    // Reset in mid-run, with a channel still armed
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(negedge core_clk_i);
    chk("idle after reset", 32'h0, {irq, sw_irq, err_irq, ep_irq, mem_req, pkt_rdy});
    wb(1'b0, usb_dma_pkg::CHEN_OFF, 32'h0);
    chk("enable after reset", 32'h0, v);
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule

`default_nettype wire
